// *** logic/pffr_defines.svh ***
// Constants of the fault injection feature register block
`ifndef PFFR_DEFINES_SVH
`define PFFR_DEFINES_SVH
`define PFFR_OP0_CAP 2'h3
`define PFFR_OP1_CAP 3'h0
`define PFFR_CRN_CAP 4'h5
`define PFFR_CRM_CAP 4'h4
`define PFFR_OP2_CAP 3'h4
`define PFFR_OP2_CTL 3'h5
`define PFFR_CAP_VALUE 64'h0000_0000_0000_0062
`define PFFR_CAP_OF_BIT 0
`define PFFR_CAP_UC_BIT 1
`define PFFR_CAP_UEU_BIT 2
`define PFFR_CAP_UER_BIT 3
`define PFFR_CAP_UEO_BIT 4
`define PFFR_CAP_DE_BIT 5
`define PFFR_CAP_CE_LSB 6
`define PFFR_CAP_CI_BIT 8
`define PFFR_CAP_ER_BIT 9
`define PFFR_CAP_PN_BIT 10
`define PFFR_CAP_CE_NONSPECIFIC 2'h1
`define PFFR_CTL_RESET 64'h0000_0000_0000_1000
`define PFFR_CTL_WR_MASK 64'h0000_0000_c000_05c0
`define PFFR_CTL_RES1 64'h0000_0000_0000_1000
`define PFFR_EC_SYSREG 6'h18
`define PFFR_STATUS_CE_CODE 2'h2
`define PFFR_NUM_RECORDS 4
`define PFFR_SEL_W 2
`endif

// *** logic/pffr_pkg.sv ***
// Types of the fault injection feature register block
package pffr_pkg;
  typedef enum logic [1:0] {
    PFFR_EL0 = 2'h0,
    PFFR_EL1 = 2'h1,
    PFFR_EL2 = 2'h2,
    PFFR_EL3 = 2'h3
  } pffr_el_type;

  typedef enum logic [1:0] {
    PFFR_INJ_CE = 2'h0,
    PFFR_INJ_DE = 2'h1,
    PFFR_INJ_UC = 2'h2,
    PFFR_INJ_UE = 2'h3
  } pffr_inj_type;

  typedef struct packed {
    logic [1:0] op0;
    logic [2:0] op1;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] op2;
  } pffr_enc_type;

  typedef struct packed {
    logic undef;
    logic trap;
    pffr_el_type trap_el;
    logic [5:0] ec;
  } pffr_check_type;

  typedef struct packed {
    logic valid;
    logic hit;
    logic undef;
    logic trap;
    pffr_el_type trap_el;
    logic [5:0] ec;
    logic [63:0] rdata;
  } pffr_resp_type;

  typedef struct packed {
    logic valid;
    logic er;
    logic of;
    logic pn;
    logic ci;
    logic de;
    logic uc;
    logic [1:0] ce;
  } pffr_status_type;
endpackage

// *** logic/pffr_access_check.sv ***
// Privilege checks and trap routing for reads and writes of the injection registers
`include "pffr_defines.svh"
module pffr_access_check
  import pffr_pkg::*;
(
  input wire pffr_el_type cur_el_i,
  input wire logic el2_enabled_i,
  input wire logic hyp_fault_injection_enable_i,
  input wire logic monitor_fault_injection_enable_i,
  input wire logic monitor_fine_grained_trap_enable_i,
  input wire logic fine_grained_trap_i,
  output pffr_check_type check_o
);
  function automatic pffr_check_type trap_to(input pffr_el_type target);
    pffr_check_type r;
    r.undef = 1'b0;
    r.trap = 1'b1;
    r.trap_el = target;
    r.ec = `PFFR_EC_SYSREG;
    return r;
  endfunction

  always_comb
  begin
    check_o = '0;
    unique case (cur_el_i)
      PFFR_EL0:
      begin
        check_o.undef = 1'b1;
      end
      PFFR_EL1:
      begin
        if (el2_enabled_i && !hyp_fault_injection_enable_i)
          check_o = trap_to(PFFR_EL2);
        else if (el2_enabled_i && monitor_fine_grained_trap_enable_i && fine_grained_trap_i)
          check_o = trap_to(PFFR_EL2);
        else if (!monitor_fault_injection_enable_i)
          check_o = trap_to(PFFR_EL3);
      end
      PFFR_EL2:
      begin
        if (!monitor_fault_injection_enable_i)
          check_o = trap_to(PFFR_EL3);
      end
      PFFR_EL3:
      begin
        check_o = '0;
      end
    endcase
  end
endmodule

// *** logic/pffr_record_window.sv ***
// Per-record injection control storage and injected error status recording
`include "pffr_defines.svh"
module pffr_record_window
  import pffr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [`PFFR_SEL_W-1:0] sel_i,
  input wire logic ctl_wr_i,
  input wire logic [63:0] ctl_wdata_i,
  input wire logic inject_i,
  input wire pffr_inj_type inject_kind_i,
  input wire logic error_reported_i,
  input wire logic status_clear_i,
  output logic [63:0] ctl_o,
  output pffr_status_type status_o,
  output logic inject_ok_o
);
  logic [63:0] ctl [`PFFR_NUM_RECORDS];
  logic [63:0] next_ctl [`PFFR_NUM_RECORDS];
  pffr_status_type status [`PFFR_NUM_RECORDS];
  pffr_status_type next_status [`PFFR_NUM_RECORDS];

  always_comb
  begin
    ctl_o = ctl[sel_i];
    status_o = status[sel_i];
    unique case (inject_kind_i)
      PFFR_INJ_CE: inject_ok_o = inject_i && (ctl[sel_i][7:6] == `PFFR_CAP_CE_NONSPECIFIC);
      PFFR_INJ_DE: inject_ok_o = inject_i;
      PFFR_INJ_UC: inject_ok_o = inject_i;
      PFFR_INJ_UE: inject_ok_o = 1'b0;
    endcase
  end

  always_comb
  begin
    for (int i = 0; i < `PFFR_NUM_RECORDS; i++)
    begin
      next_ctl[i] = ctl[i];
      next_status[i] = status[i];
      if (ctl_wr_i && sel_i == i[`PFFR_SEL_W-1:0])
        next_ctl[i] = (ctl_wdata_i & `PFFR_CTL_WR_MASK) | `PFFR_CTL_RES1;
      if (status_clear_i && sel_i == i[`PFFR_SEL_W-1:0])
        next_status[i] = '0;
      if (inject_ok_o && sel_i == i[`PFFR_SEL_W-1:0])
      begin
        next_status[i].valid = 1'b1;
        next_status[i].er = error_reported_i;
        next_status[i].of = status[i].valid;
        next_status[i].pn = 1'b0;
        next_status[i].ci = 1'b0;
        next_status[i].de = (inject_kind_i == PFFR_INJ_DE);
        next_status[i].uc = (inject_kind_i == PFFR_INJ_UC);
        next_status[i].ce = (inject_kind_i == PFFR_INJ_CE) ? `PFFR_STATUS_CE_CODE : 2'h0;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < `PFFR_NUM_RECORDS; i++)
    begin
      if (rst_i)
      begin
        ctl[i] <= `PFFR_CTL_RESET;
        status[i] <= '0;
      end
      else
      begin
        ctl[i] <= next_ctl[i];
        status[i] <= next_status[i];
      end
    end
  end
endmodule

// *** logic/pffr_top.sv ***
// Fault injection capability and control register access block
`include "pffr_defines.svh"
module pffr_top
  import pffr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire pffr_enc_type req_enc_i,
  input wire logic [63:0] req_wdata_i,
  input wire pffr_el_type cur_el_i,
  input wire logic el2_enabled_i,
  input wire logic hyp_fault_injection_enable_i,
  input wire logic monitor_fault_injection_enable_i,
  input wire logic monitor_fine_grained_trap_enable_i,
  input wire logic hyp_fine_grained_read_traps_i,
  input wire logic [`PFFR_SEL_W-1:0] record_selection_field_i,
  input wire logic inject_i,
  input wire pffr_inj_type inject_kind_i,
  input wire logic error_reported_i,
  input wire logic status_clear_i,
  output logic req_ready_o,
  output pffr_resp_type resp_o,
  output pffr_status_type selected_error_status_o,
  output logic inject_refused_o
);
  typedef enum logic [1:0] {
    PFFR_IDLE = 2'h1,
    PFFR_ANSWER = 2'h2
  } pffr_state_type;

  pffr_state_type state;
  pffr_state_type next_state;
  pffr_resp_type next_resp;
  logic next_inject_refused;
  logic take;
  logic hit_cap;
  logic hit_ctl;
  logic allowed;
  logic ctl_wr;
  logic inject_ok;
  logic [63:0] ctl_sel;
  pffr_check_type check;

  function automatic logic enc_match(input pffr_enc_type e, input logic [2:0] op2);
    return e.op0 == `PFFR_OP0_CAP && e.op1 == `PFFR_OP1_CAP && e.crn == `PFFR_CRN_CAP
      && e.crm == `PFFR_CRM_CAP && e.op2 == op2;
  endfunction

  pffr_access_check u_check (
    .cur_el_i(cur_el_i),
    .el2_enabled_i(el2_enabled_i),
    .hyp_fault_injection_enable_i(hyp_fault_injection_enable_i),
    .monitor_fault_injection_enable_i(monitor_fault_injection_enable_i),
    .monitor_fine_grained_trap_enable_i(monitor_fine_grained_trap_enable_i),
    .fine_grained_trap_i(hyp_fine_grained_read_traps_i && hit_cap),
    .check_o(check)
  );

  pffr_record_window u_window (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sel_i(record_selection_field_i),
    .ctl_wr_i(ctl_wr),
    .ctl_wdata_i(req_wdata_i),
    .inject_i(inject_i),
    .inject_kind_i(inject_kind_i),
    .error_reported_i(error_reported_i),
    .status_clear_i(status_clear_i),
    .ctl_o(ctl_sel),
    .status_o(selected_error_status_o),
    .inject_ok_o(inject_ok)
  );

  // Request decode
  always_comb
  begin
    req_ready_o = (state == PFFR_IDLE);
    take = req_valid_i && req_ready_o;
    hit_cap = enc_match(req_enc_i, `PFFR_OP2_CAP);
    hit_ctl = enc_match(req_enc_i, `PFFR_OP2_CTL);
    allowed = !check.undef && !check.trap;
    ctl_wr = take && hit_ctl && req_write_i && allowed;
  end

  // Answer sequencing and read data
  always_comb
  begin
    next_state = state;
    next_resp = resp_o;
    next_resp.valid = 1'b0;
    unique case (state)
      PFFR_IDLE:
      begin
        if (take)
        begin
          next_state = PFFR_ANSWER;
          next_resp = '0;
          next_resp.valid = 1'b1;
          next_resp.hit = hit_cap || hit_ctl;
          if (hit_cap || hit_ctl)
          begin
            next_resp.undef = check.undef;
            next_resp.trap = check.trap;
            next_resp.trap_el = check.trap_el;
            next_resp.ec = check.ec;
          end
          if (allowed && !req_write_i && hit_cap)
            next_resp.rdata = `PFFR_CAP_VALUE;
          else if (allowed && !req_write_i && hit_ctl)
            next_resp.rdata = ctl_sel;
        end
      end
      PFFR_ANSWER:
      begin
        next_state = PFFR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= PFFR_IDLE;
      resp_o <= '0;
    end
    else
    begin
      state <= next_state;
      resp_o <= next_resp;
    end
  end

  // Injection refusal report
  always_comb
  begin
    next_inject_refused = inject_i && !inject_ok;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      inject_refused_o <= 1'b0;
    else
      inject_refused_o <= next_inject_refused;
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic cap_ok_read;
  logic ctl_ok_read;
  assign cap_ok_read = take && hit_cap && !req_write_i && allowed;
  assign ctl_ok_read = take && hit_ctl && !req_write_i && allowed;

  cap_ce_field_a: assert property (cap_ok_read |=> resp_o.rdata[7:6] == 2'h1)
    else $error("capability corrected field wrong");
  cap_de_bit_a: assert property (cap_ok_read |=> resp_o.valid && resp_o.rdata[5])
    else $error("capability deferred bit not set");
  cap_uc_bit_a: assert property (cap_ok_read |=> resp_o.rdata[1] && resp_o.hit)
    else $error("capability uncontainable bit not set");
  cap_ue_zero_a: assert property (cap_ok_read |=> resp_o.rdata[4:2] == 3'h0)
    else $error("capability unsupported bits not zero");
  cap_ci_zero_a: assert property (cap_ok_read |=> !resp_o.rdata[8])
    else $error("capability critical bit not zero");
  cap_reserved_a: assert property (cap_ok_read |=> resp_o.rdata[63:9] == 55'h0)
    else $error("capability reserved bits not zero");
  cap_write_ignored_a: assert property (
    take && hit_cap && req_write_i |=> resp_o.rdata == 64'h0 ##1 !resp_o.valid)
    else $error("capability write not ignored");

  status_er_a: assert property (
    inject_ok |=> record_selection_field_i != $past(record_selection_field_i)
    || selected_error_status_o.er == $past(error_reported_i))
    else $error("error reported flag wrong");
  status_of_a: assert property (
    inject_ok && selected_error_status_o.valid && !status_clear_i |=>
    record_selection_field_i != $past(record_selection_field_i)
    || selected_error_status_o.of)
    else $error("overflow flag not set");
  status_pn_a: assert property (
    inject_ok |=> record_selection_field_i != $past(record_selection_field_i)
    || (!selected_error_status_o.pn && !selected_error_status_o.ci))
    else $error("poison or critical flag set");

  el0_undef_a: assert property (
    take && (hit_cap || hit_ctl) && cur_el_i == PFFR_EL0 |=> resp_o.undef && !resp_o.trap)
    else $error("application read not undefined");
  hyp_trap_a: assert property (
    take && hit_cap && cur_el_i == PFFR_EL1 && el2_enabled_i && !hyp_fault_injection_enable_i
    |=> resp_o.trap && resp_o.trap_el == PFFR_EL2 && resp_o.ec == 6'h18)
    else $error("hypervisor enable trap missing");
  fgt_trap_a: assert property (
    take && hit_cap && cur_el_i == PFFR_EL1 && el2_enabled_i && hyp_fault_injection_enable_i
    && monitor_fine_grained_trap_enable_i && hyp_fine_grained_read_traps_i
    |=> resp_o.trap && resp_o.trap_el == PFFR_EL2 && resp_o.ec == 6'h18)
    else $error("fine grained trap missing");
  mon_trap_a: assert property (
    take && hit_cap && cur_el_i == PFFR_EL2 && !monitor_fault_injection_enable_i
    |=> resp_o.trap && resp_o.trap_el == PFFR_EL3 && resp_o.ec == 6'h18)
    else $error("monitor enable trap missing");
  el3_read_a: assert property (
    take && hit_cap && !req_write_i && cur_el_i == PFFR_EL3
    |=> !resp_o.trap && !resp_o.undef && resp_o.rdata == 64'h62)
    else $error("monitor read not returned");
  enc_hit_a: assert property (
    take |=> resp_o.hit == ($past(req_enc_i) == 16'hc2a4 || $past(req_enc_i) == 16'hc2a5))
    else $error("encoding decode wrong");
  ctl_window_a: assert property (ctl_ok_read |=> resp_o.rdata == $past(ctl_sel))
    else $error("control window data wrong");
  ctl_res1_a: assert property (ctl_ok_read |=> resp_o.rdata[12] && resp_o.rdata[63:32] == 32'h0)
    else $error("control fixed bits wrong");
  ctl_fixed_a: assert property ((ctl_sel & ~`PFFR_CTL_WR_MASK) == `PFFR_CTL_RES1)
    else $error("control fixed bits not kept");

  resp_pulse_a: assert property (
    take |=> resp_o.valid && !req_ready_o ##1 !resp_o.valid && req_ready_o)
    else $error("answer pulse or ready wrong");
  miss_answer_a: assert property (
    take && req_enc_i != 16'hc2a4 && req_enc_i != 16'hc2a5
    |=> !resp_o.hit && !resp_o.undef && !resp_o.trap && resp_o.rdata == 64'h0)
    else $error("unmatched encoding answered");
  el1_mon_trap_a: assert property (
    take && hit_cap && cur_el_i == PFFR_EL1 && !monitor_fault_injection_enable_i
    && (!el2_enabled_i || (hyp_fault_injection_enable_i
    && !(monitor_fine_grained_trap_enable_i && hyp_fine_grained_read_traps_i)))
    |=> resp_o.trap && resp_o.trap_el == PFFR_EL3 && resp_o.ec == 6'h18)
    else $error("kernel monitor trap missing");
  el2_read_a: assert property (
    take && hit_cap && !req_write_i && cur_el_i == PFFR_EL2
    && monitor_fault_injection_enable_i
    |=> !resp_o.trap && !resp_o.undef && resp_o.rdata == 64'h62)
    else $error("hypervisor read not returned");
  el3_ctl_read_a: assert property (
    take && hit_ctl && !req_write_i && cur_el_i == PFFR_EL3
    |=> !resp_o.trap && !resp_o.undef && resp_o.rdata == $past(ctl_sel))
    else $error("monitor control read not returned");
  trap_no_data_a: assert property (
    take && (hit_cap || hit_ctl) && (check.undef || check.trap) |=> resp_o.rdata == 64'h0)
    else $error("refused read returned data");
  ctl_write_lands_a: assert property (
    ctl_wr |=> record_selection_field_i != $past(record_selection_field_i)
    || ctl_sel == (($past(req_wdata_i) & `PFFR_CTL_WR_MASK) | `PFFR_CTL_RES1))
    else $error("control write not stored");
  cap_wr_no_ctl_a: assert property (
    take && hit_cap && req_write_i |=> $stable(ctl_sel)
    || record_selection_field_i != $past(record_selection_field_i))
    else $error("capability write changed control");

  status_valid_a: assert property (
    inject_ok |=> record_selection_field_i != $past(record_selection_field_i)
    || selected_error_status_o.valid)
    else $error("injected error not recorded");
  kind_flags_a: assert property (
    inject_ok |=> record_selection_field_i != $past(record_selection_field_i)
    || (selected_error_status_o.de == ($past(inject_kind_i) == PFFR_INJ_DE)
    && selected_error_status_o.uc == ($past(inject_kind_i) == PFFR_INJ_UC)))
    else $error("deferred or uncontainable flag wrong");
  ce_code_a: assert property (
    inject_ok && inject_kind_i == PFFR_INJ_CE
    |=> record_selection_field_i != $past(record_selection_field_i)
    || selected_error_status_o.ce == 2'h2)
    else $error("corrected error code wrong");
  ce_gated_a: assert property (
    inject_i && inject_kind_i == PFFR_INJ_CE && ctl_sel[7:6] != 2'h1 |=> inject_refused_o)
    else $error("corrected error not refused");
  ue_refused_a: assert property (
    inject_i && inject_kind_i == PFFR_INJ_UE && !status_clear_i
    |=> inject_refused_o && ($stable(selected_error_status_o)
    || record_selection_field_i != $past(record_selection_field_i)))
    else $error("unrecoverable error recorded");
  refused_quiet_a: assert property (
    !inject_i |=> !inject_refused_o)
    else $error("refusal without injection");

  cap_read_c: cover property (cap_ok_read ##1 resp_o.valid);
  ce_inject_c: cover property (inject_ok && inject_kind_i == PFFR_INJ_CE);
  ctl_write_read_c: cover property (ctl_wr ##2 ctl_ok_read);
  trap_el2_c: cover property (resp_o.trap && resp_o.trap_el == PFFR_EL2);
  inject_twice_c: cover property (inject_ok ##[1:4] inject_ok);
endmodule

// *** test/tb_pffr_top.sv ***
// Self-checking bench for the fault injection register block
`include "pffr_defines.svh"
module tb_pffr_top
  import pffr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i;
  logic rst_i;
  logic req_valid_i;
  logic req_write_i;
  pffr_enc_type req_enc_i;
  logic [63:0] req_wdata_i;
  logic [6:0] cfg;
  logic [1:0] sel;
  logic inject_i;
  pffr_inj_type inject_kind_i;
  logic error_reported_i;
  logic status_clear_i;
  logic req_ready_o;
  pffr_resp_type resp_o;
  pffr_status_type st_o;
  logic inject_refused_o;
  pffr_status_type st;
  int err_count;
  int n_compared;
  // Privilege setups {level, hyp on, hyp enable, monitor enable, fine enable, fine trap}
  localparam logic [6:0] PCFG [9] = '{7'h1f, 7'h34, 7'h3f, 7'h3a, 7'h27, 7'h5b, 7'h54, 7'h60,
    7'h3d};
  // Expected {undefined, trap, trap level}
  localparam logic [3:0] PEXP [9] = '{4'h8, 4'h6, 4'h6, 4'h7, 4'h0, 4'h7, 4'h0, 4'h0, 4'h0};
  // Corrected field 01, deferred and uncontainable set, all else zero
  localparam logic [63:0] CAP = 64'h0000_0000_0000_0062;

  pffr_top u_dut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .req_valid_i(req_valid_i),
    .req_write_i(req_write_i),
    .req_enc_i(req_enc_i),
    .req_wdata_i(req_wdata_i),
    .cur_el_i(pffr_el_type'(cfg[6:5])),
    .el2_enabled_i(cfg[4]),
    .hyp_fault_injection_enable_i(cfg[3]),
    .monitor_fault_injection_enable_i(cfg[2]),
    .monitor_fine_grained_trap_enable_i(cfg[1]),
    .hyp_fine_grained_read_traps_i(cfg[0]),
    .record_selection_field_i(sel),
    .inject_i(inject_i),
    .inject_kind_i(inject_kind_i),
    .error_reported_i(error_reported_i),
    .status_clear_i(status_clear_i),
    .req_ready_o(req_ready_o),
    .resp_o(resp_o),
    .selected_error_status_o(st_o),
    .inject_refused_o(inject_refused_o)
  );

  always #25 clk_i = ~clk_i;

  task automatic cmp_word(input string name, input logic [63:0] exp, input logic [63:0] got);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cmp_flag(input string name, input logic exp, input logic got);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // One register access, held until the taking edge, answer checked just after that edge
  task automatic access(input logic wr, input logic [2:0] op2, input logic [63:0] wd);
    int n;
    n = 0;
    #1;
    while (req_ready_o !== 1'b1 && n < 8)
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (req_ready_o !== 1'b1)
    begin
      $display("MISMATCH ready expected 1 seen timeout");
      err_count++;
      report_and_stop();
    end
    else
    begin
      @(posedge clk_i);
      req_valid_i <= 1'b1;
      req_write_i <= wr;
      req_enc_i <= '{op0: 2'h3, op1: 3'h0, crn: 4'h5, crm: 4'h4, op2: op2};
      req_wdata_i <= wd;
      @(posedge clk_i);
      req_valid_i <= 1'b0;
      #1;
      cmp_flag("resp valid", 1'b1, resp_o.valid);
      cmp_flag("ready busy", 1'b0, req_ready_o);
    end
  endtask

  // One injected error pulse; snapshot of status and refusal after the taking edge
  task automatic inj(input pffr_inj_type k, input logic er, input logic refused);
    @(posedge clk_i);
    inject_i <= 1'b1;
    inject_kind_i <= k;
    error_reported_i <= er;
    @(posedge clk_i);
    inject_i <= 1'b0;
    #1;
    st = st_o;
    cmp_flag("refused", refused, inject_refused_o);
  endtask

  initial
  begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    req_valid_i = 1'b0;
    req_write_i = 1'b0;
    req_enc_i = '0;
    req_wdata_i = 64'h0;
    cfg = 7'h60;
    sel = 2'h0;
    inject_i = 1'b0;
    inject_kind_i = PFFR_INJ_CE;
    error_reported_i = 1'b0;
    status_clear_i = 1'b0;
    err_count = 0;
    n_compared = 0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    cmp_word("reset rdata", 64'h0, resp_o.rdata);
    cmp_word("reset status", 64'h0, {55'h0, st_o});
    access(1'b0, 3'h4, 64'h0);
    cmp_flag("cap hit", 1'b1, resp_o.hit);
    cmp_word("cap rdata", CAP, resp_o.rdata);
    $display("test cap_read done");
    for (int i = 0; i < 9; i++)
    begin
      @(posedge clk_i);
      cfg <= PCFG[i];
      access(1'b0, 3'h4, 64'h0);
      cmp_flag("undef", PEXP[i][3], resp_o.undef);
      cmp_flag("trap", PEXP[i][2], resp_o.trap);
      if (PEXP[i][2])
      begin
        cmp_word("trap el", {62'h0, PEXP[i][1:0]}, {62'h0, resp_o.trap_el});
        cmp_word("ec", 64'h18, {58'h0, resp_o.ec});
      end
      cmp_word("priv rdata", (PEXP[i] == 4'h0) ? CAP : 64'h0, resp_o.rdata);
    end
    $display("test privilege done");
    @(posedge clk_i);
    cfg <= 7'h60;
    access(1'b1, 3'h4, 64'hffff_ffff_ffff_ffff);
    access(1'b0, 3'h4, 64'h0);
    cmp_word("cap after write", CAP, resp_o.rdata);
    access(1'b0, 3'h7, 64'h0);
    cmp_flag("other hit", 1'b0, resp_o.hit);
    $display("test cap_write done");
    access(1'b1, 3'h5, 64'hffff_ffff_ffff_ffff);
    @(posedge clk_i);
    sel <= 2'h1;
    access(1'b0, 3'h5, 64'h0);
    cmp_word("ctl record 1", `PFFR_CTL_RESET, resp_o.rdata);
    @(posedge clk_i);
    sel <= 2'h0;
    access(1'b0, 3'h5, 64'h0);
    cmp_word("ctl record 0", `PFFR_CTL_WR_MASK | `PFFR_CTL_RES1, resp_o.rdata);
    $display("test window done");
    @(posedge clk_i);
    sel <= 2'h2;
    inj(PFFR_INJ_DE, 1'b1, 1'b0);
    cmp_word("status de", 64'h188, {55'h0, st});
    inj(PFFR_INJ_UC, 1'b0, 1'b0);
    cmp_word("status uc", 64'h144, {55'h0, st});
    inj(PFFR_INJ_UE, 1'b1, 1'b1);
    cmp_word("status ue", 64'h144, {55'h0, st});
    inj(PFFR_INJ_CE, 1'b1, 1'b1);
    access(1'b1, 3'h5, 64'h0000_0000_0000_0040);
    inj(PFFR_INJ_CE, 1'b1, 1'b0);
    cmp_word("status ce", 64'h1c2, {55'h0, st});
    @(posedge clk_i);
    status_clear_i <= 1'b1;
    @(posedge clk_i);
    status_clear_i <= 1'b0;
    #1;
    cmp_flag("cleared valid", 1'b0, st_o.valid);
    $display("test inject done");
    @(posedge clk_i);
    rst_i <= 1'b1;
    sel <= 2'h0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    cmp_word("rerun status", 64'h0, {55'h0, st_o});
    access(1'b0, 3'h5, 64'h0);
    cmp_word("ctl after reset", `PFFR_CTL_RESET, resp_o.rdata);
    $display("test reset done");
    report_and_stop();
  end
endmodule
